// >>> logic/dam_pkg.sv
// Shared constants and types for the DRAM address multiplexer
package dam_pkg;
  localparam int ADDR_W = 32;
  // Port size codes of the per-block port-size field
  localparam logic [1:0] PS_32BIT = 2'h0;
  localparam logic [1:0] PS_8BIT = 2'h1;
  // Multiplexed pin ranges
  localparam int COL_LOW_FIRST = 9;
  localparam int COL_LOW_LAST = 16;
  localparam int COL_SPLIT_PIN = 17;
  localparam int COL_HIGH_FIRST = 18;
  localparam int COL_HIGH_LAST = 25;
  localparam int COL_LOW_SUM = 17;
  localparam int COL_SPLIT_WIDE_BIT = 16;
  // Fixed page size for page-mode operation
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_SHIFT = $clog2(PAGE_BYTES);
  // Default strobe timing in clocks
  localparam int RCD_CYCLES = 1;
  localparam int CAS_CYCLES = 2;
  localparam int CNT_W = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [1:0] port_size_select;
    logic write;
    logic sync_mode;
  } dam_req_t;

  typedef struct packed {
    logic row_strobe_n;
    logic col_strobe_n;
    logic dram_write_strobe_n;
  } dam_strobe_t;
endpackage

// >>> logic/dam_col_map.sv
// Column address map of the multiplexed DRAM address pins
`timescale 1ns/1ps
module dam_col_map
(
  input wire logic [dam_pkg::ADDR_W-1:0] logical_addr,
  input wire logic [1:0] port_size_select,
  output logic [dam_pkg::ADDR_W-1:0] col_pins
);
  // Low pins carry bits in reverse order, high pins one bit below the pin
  always_comb
  begin
    col_pins = logical_addr;
    for (int i = dam_pkg::COL_LOW_FIRST; i <= dam_pkg::COL_LOW_LAST; i++)
    begin
      col_pins[i] = logical_addr[dam_pkg::COL_LOW_SUM - i];
    end
    for (int i = dam_pkg::COL_HIGH_FIRST; i <= dam_pkg::COL_HIGH_LAST; i++)
    begin
      col_pins[i] = logical_addr[i - 1];
    end
    // Only byte ports need bit 0 here; wider ports reuse the pin for bit 16
    if (port_size_select == dam_pkg::PS_8BIT)
    begin
      col_pins[dam_pkg::COL_SPLIT_PIN] = logical_addr[0];
    end
    else
    begin
      col_pins[dam_pkg::COL_SPLIT_PIN] =
        logical_addr[dam_pkg::COL_SPLIT_WIDE_BIT];
    end
  end
endmodule

// >>> logic/dam_address_mux.sv
// DRAM row/column address multiplexer with its strobe sequencer
// Function
// - The block drives row, column and write strobes, muxes the address and ends each access.
// - The mux pattern is the same in sync and async mode; only termination differs.
// - In the row phase every pin carries the logical address bit of its own index.
// - In the column phase pins 9 to 16 carry logical bits 8 down to 1.
// - In the column phase pin 17 carries bit 0 for byte ports, else bit 16.
// - In the column phase pins 18 to 25 carry the logical bit one below the pin.
// - Bit 0 is used only by byte ports; 16-bit ports drop bit 0, 32-bit drop bits 0 and 1.
// - Every block has a fixed 512 byte page for page-mode purposes.
// - Port size code 00 is 32 bits, 01 is 8 bits, 1x is 16 bits.
`timescale 1ns/1ps
module dam_address_mux
#(
  parameter int RCD = dam_pkg::RCD_CYCLES,
  parameter int CAS = dam_pkg::CAS_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire dam_pkg::dam_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [dam_pkg::ADDR_W-1:0] addr_pins,
  output dam_pkg::dam_strobe_t strobes,
  output logic cycle_done,
  output logic page_hit
);
  typedef enum logic [3:0] {
    DAM_IDLE = 4'b0001,
    DAM_ROW = 4'b0010,
    DAM_COL = 4'b0100,
    DAM_CAS = 4'b1000
  } dam_state_t;

  dam_state_t state_reg;
  dam_state_t state_next;
  logic [dam_pkg::ADDR_W-1:0] lat_addr_reg;
  logic [1:0] ps_reg;
  logic write_reg;
  logic sync_reg;
  logic [dam_pkg::CNT_W-1:0] cnt_reg;
  logic [dam_pkg::CNT_W-1:0] cnt_next;
  logic [dam_pkg::ADDR_W-1:0] pins_next;
  logic done_next;
  logic async_pend_reg;
  logic page_valid_reg;
  logic [dam_pkg::ADDR_W-1:0] last_addr_reg;

  localparam logic [dam_pkg::CNT_W-1:0] RCD_LAST =
    dam_pkg::CNT_W'(RCD - 1);
  localparam logic [dam_pkg::CNT_W-1:0] CAS_LAST =
    dam_pkg::CNT_W'(CAS - 1);

  // Wide ports never address below their own width
  function automatic logic [dam_pkg::ADDR_W-1:0] drop_low
  (
    input logic [dam_pkg::ADDR_W-1:0] a,
    input logic [1:0] ps
  );
    logic [dam_pkg::ADDR_W-1:0] r;
    r = a;
    if (ps == dam_pkg::PS_32BIT)
    begin
      r[1:0] = 2'h0;
    end
    else if (ps != dam_pkg::PS_8BIT)
    begin
      r[0] = 1'b0;
    end
    return r;
  endfunction

  wire logic accept = req_valid && (state_reg == DAM_IDLE);
  wire logic [dam_pkg::ADDR_W-1:0] req_eff =
    drop_low(req.addr, req.port_size_select);
  wire logic [dam_pkg::ADDR_W-1:0] col_pins;
  wire logic row_done = (cnt_reg == RCD_LAST);
  wire logic cas_done = (cnt_reg == CAS_LAST);
  // Page compare ignores the offset inside the 512 byte page
  wire logic same_page = page_valid_reg &&
    (req_eff[dam_pkg::ADDR_W-1:dam_pkg::PAGE_SHIFT] ==
     last_addr_reg[dam_pkg::ADDR_W-1:dam_pkg::PAGE_SHIFT]);

  assign req_ready = (state_reg == DAM_IDLE);

  dam_col_map u_col_map
  (
    .logical_addr(lat_addr_reg),
    .port_size_select(ps_reg),
    .col_pins(col_pins)
  );

  // Sequencer: the pins move to the column map one state before CAS drops
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pins_next = addr_pins;
    done_next = 1'b0;
    unique case (state_reg)
      DAM_IDLE:
      begin
        if (req_valid)
        begin
          state_next = DAM_ROW;
          cnt_next = '0;
          pins_next = req_eff;
        end
      end
      DAM_ROW:
      begin
        cnt_next = cnt_reg + 1'b1;
        if (row_done)
        begin
          state_next = DAM_COL;
          pins_next = col_pins;
        end
      end
      DAM_COL:
      begin
        state_next = DAM_CAS;
        cnt_next = '0;
      end
      DAM_CAS:
      begin
        cnt_next = cnt_reg + 1'b1;
        // Sync mode ends in the last strobe cycle, async one later
        if (sync_reg && cas_done)
        begin
          done_next = 1'b1;
        end
        if (cas_done)
        begin
          state_next = DAM_IDLE;
        end
      end
    endcase
  end

  // State, pins and termination
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= DAM_IDLE;
      cnt_reg <= '0;
      addr_pins <= '0;
      cycle_done <= 1'b0;
      async_pend_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_pins <= pins_next;
      // Async ends one clock after the last strobe cycle, not with it
      async_pend_reg <= (state_reg == DAM_CAS) && cas_done && !sync_reg;
      cycle_done <= done_next || async_pend_reg;
    end
  end

  // Strobes follow the state; RAS low from row through column strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      strobes <= '{1'b1, 1'b1, 1'b1};
    end
    else
    begin
      strobes.row_strobe_n <= !(state_next != DAM_IDLE);
      strobes.col_strobe_n <= !(state_next == DAM_CAS);
      strobes.dram_write_strobe_n <=
        !((state_next == DAM_CAS) && write_reg);
    end
  end

  // Request capture and page tracking
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lat_addr_reg <= '0;
      ps_reg <= dam_pkg::PS_32BIT;
      write_reg <= 1'b0;
      sync_reg <= 1'b0;
      page_valid_reg <= 1'b0;
      last_addr_reg <= '0;
      page_hit <= 1'b0;
    end
    else if (accept)
    begin
      lat_addr_reg <= req_eff;
      ps_reg <= req.port_size_select;
      write_reg <= req.write;
      sync_reg <= req.sync_mode;
      page_valid_reg <= 1'b1;
      last_addr_reg <= req_eff;
      page_hit <= same_page;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence row_open_s;
    accept ##1 (state_reg == DAM_ROW && !strobes.row_strobe_n);
  endsequence

  sequence col_strobe_s;
    ##[1:20] (state_reg == DAM_CAS && !strobes.col_strobe_n);
  endsequence

  row_phase_pins_a: assert property (
    state_reg == DAM_ROW |-> addr_pins[25:9] == lat_addr_reg[25:9])
    else $error("row phase pins differ from logical address");

  col_low_pins_a: assert property (
    state_reg == DAM_CAS |->
      addr_pins[9] == lat_addr_reg[8] && addr_pins[16] == lat_addr_reg[1])
    else $error("low column pins wrong");

  pin17_byte_a: assert property (
    state_reg == DAM_CAS && ps_reg == dam_pkg::PS_8BIT |->
      addr_pins[17] == lat_addr_reg[0])
    else $error("pin 17 should carry bit 0 for byte port");

  pin17_wide_a: assert property (
    state_reg == DAM_CAS && ps_reg != dam_pkg::PS_8BIT |->
      addr_pins[17] == lat_addr_reg[16])
    else $error("pin 17 should carry bit 16 for wide port");

  col_high_pins_a: assert property (
    state_reg == DAM_CAS |-> addr_pins[25:18] == lat_addr_reg[24:17])
    else $error("high column pins wrong");

  low_bits_drop_a: assert property (
    state_reg != DAM_IDLE && ps_reg == dam_pkg::PS_32BIT |->
      lat_addr_reg[1:0] == 2'h0)
    else $error("32-bit port kept low address bits");

  mux_before_cas_a: assert property (
    $fell(strobes.col_strobe_n) |->
      $past(state_reg) == DAM_COL && $stable(addr_pins))
    else $error("pins not switched before column strobe");

  access_seq_a: assert property (
    row_open_s |-> col_strobe_s)
    else $error("column strobe missing after row strobe");

  sync_term_a: assert property (
    cycle_done && $past(sync_reg) |->
      $past(state_reg) == DAM_CAS && !$past(strobes.col_strobe_n))
    else $error("sync termination not right after column strobe");

  async_term_a: assert property (
    cycle_done && !$past(sync_reg) |-> $past(state_reg, 2) == DAM_CAS)
    else $error("async termination not one clock after column strobe");

  page_match_a: assert property (
    accept && same_page |=> page_hit)
    else $error("page hit missed within 512 byte page");
endmodule

// >>> sim/dam_dram_model.sv
// Behavioural clocked DRAM monitor latching row, column and write from the multiplexed pins
`timescale 1ns/1ps
module dam_dram_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [dam_pkg::ADDR_W-1:0] addr_pins,
  input wire dam_pkg::dam_strobe_t strobes,
  output logic [dam_pkg::ADDR_W-1:0] row_seen,
  output logic [dam_pkg::ADDR_W-1:0] col_seen,
  output logic wr_seen
);
  logic row_n_reg;
  logic col_n_reg;
  // Pins as they stood before the last edge, to catch a late column switch
  logic [dam_pkg::ADDR_W-1:0] pins_d_reg;
  // Latch one edge after a strobe falls, so the pins must already be set up
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      row_n_reg <= 1'b1;
      col_n_reg <= 1'b1;
      row_seen <= 32'h0000_0000;
      col_seen <= 32'h0000_0000;
      wr_seen <= 1'b0;
      pins_d_reg <= 32'h0000_0000;
    end
    else
    begin
      pins_d_reg <= addr_pins;
      row_n_reg <= strobes.row_strobe_n;
      col_n_reg <= strobes.col_strobe_n;
      if (row_n_reg && !strobes.row_strobe_n)
        row_seen <= addr_pins;
      if (col_n_reg && !strobes.col_strobe_n)
      begin
        col_seen <= pins_d_reg;
        wr_seen <= !strobes.dram_write_strobe_n;
      end
    end
  end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the DRAM address multiplexer
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  dam_pkg::dam_req_t req = '0;
  logic req_valid = 1'b0;
  logic req_ready;
  logic [dam_pkg::ADDR_W-1:0] addr_pins;
  logic [dam_pkg::ADDR_W-1:0] row_seen;
  logic [dam_pkg::ADDR_W-1:0] col_seen;
  dam_pkg::dam_strobe_t strobes;
  logic cycle_done;
  logic page_hit;
  logic wr_seen;
  logic [31:0] prev_addr = 32'h0000_0000;
  logic have_prev = 1'b0;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_sync;
  int n_async;

  always #2 clk = ~clk;

  dam_address_mux dut (.clk(clk), .reset(reset), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .addr_pins(addr_pins),
    .strobes(strobes), .cycle_done(cycle_done), .page_hit(page_hit));

  dam_dram_model mem (.clk(clk), .reset(reset), .addr_pins(addr_pins),
    .strobes(strobes), .row_seen(row_seen), .col_seen(col_seen),
    .wr_seen(wr_seen));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      conclude();
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Wide ports never use the low byte-lane bits
  function automatic logic [31:0] masked(logic [31:0] a, logic [1:0] ps);
    masked = a;
    if (ps == 2'h0)
      masked[1:0] = 2'h0;
    if (ps[1])
      masked[0] = 1'b0;
  endfunction

  function automatic logic [31:0] col_exp(logic [31:0] a, logic [1:0] ps);
    logic [31:0] m;
    m = masked(a, ps);
    col_exp = m;
    for (int i = 9; i <= 16; i++)
      col_exp[i] = m[17 - i];
    col_exp[17] = (ps == 2'h1) ? m[0] : m[16];
    for (int i = 18; i <= 25; i++)
      col_exp[i] = m[i - 1];
  endfunction

  // One full access; n counts cycles from the accept to termination
  task automatic access(input logic [31:0] a, input logic [1:0] ps,
    input logic wr, input logic sm, output int n);
    logic r;
    logic hit;
    hit = have_prev && (prev_addr[31:9] == a[31:9]);
    @(posedge clk);
    req <= '{addr: a, port_size_select: ps, write: wr, sync_mode: sm};
    req_valid <= 1'b1;
    r = 1'b0;
    while (!r)
    begin
      @(negedge clk);
      r = (req_ready === 1'b1);
      @(posedge clk);
    end
    req_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (n == 2)
        check("busy ready", 32'h0000_0000, {31'h0, req_ready});
    end
    while (cycle_done !== 1'b1 && n < 20);
    check("done", 32'h0000_0001, {31'h0, cycle_done});
    check("row", masked(a, ps), row_seen);
    check("column", col_exp(a, ps), col_seen);
    check("write", {31'h0, wr}, {31'h0, wr_seen});
    check("page hit", {31'h0, hit}, {31'h0, page_hit});
    prev_addr = a;
    have_prev = 1'b1;
  endtask

  task automatic t_reset();
    @(negedge clk);
    check("reset pins", 32'h0000_0000, addr_pins);
    check("reset strobes", 32'h0000_0007, {29'h0, strobes});
    check("reset ready", 32'h0000_0001, {31'h0, req_ready});
    check("reset flags", 32'h0000_0000, {30'h0, cycle_done, page_hit});
  endtask

  task automatic t_port_sizes();
    int n;
    for (int p = 0; p < 4; p++)
      access(32'h5A3C_E1F7 + p * 32'h0010_0000, p[1:0], 1'b0, 1'b1, n);
  endtask

  task automatic t_modes();
    access(32'h0155_AA03, 2'h1, 1'b0, 1'b1, n_sync);
    access(32'h02AA_55FE, 2'h1, 1'b0, 1'b0, n_async);
    check("sync cycles", dam_pkg::RCD_CYCLES + dam_pkg::CAS_CYCLES + 2,
      n_sync);
    check("async extra", n_sync + 1, n_async);
  endtask

  task automatic t_write_pages();
    int n;
    access(32'h0012_3401, 2'h2, 1'b1, 1'b0, n);
    access(32'h0012_35FF, 2'h0, 1'b1, 1'b1, n);
    access(32'h0012_3600, 2'h1, 1'b0, 1'b1, n);
  endtask

  initial
  begin
    repeat (9) @(posedge clk);
    t_reset();
    @(posedge clk);
    reset <= 1'b0;
    t_port_sizes();
    t_modes();
    t_write_pages();
    conclude();
  end
endmodule
